// File: common/ewsg_pkg.sv
package ewsg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  CFG_INDEX      = 8'h28;
  localparam logic [7:0]  MUL_INDEX      = 8'h2B;
  localparam logic [9:0]  CFG_BYTE_ADDR  = {CFG_INDEX, 2'b00};
  localparam logic [9:0]  MUL_BYTE_ADDR  = {MUL_INDEX, 2'b00};

  // Field positions of the wait count configuration and multiplier registers
  localparam int          SPLIT_BIT      = 15;
  localparam int          IO_LSB         = 12;
  localparam int          DHI_LSB        = 9;
  localparam int          DLO_LSB        = 6;
  localparam int          PHI_LSB        = 3;
  localparam int          PLO_LSB        = 0;
  localparam int          DOUBLE_BIT     = 0;

  // Values after reset
  localparam logic [15:0] CFG_RESET      = 16'h7FFF;
  localparam logic        DOUBLE_RESET   = 1'b0;

  // Address split points
  localparam int          DATA_SPLIT_BIT = 15;
  localparam int          PROG_WIDE_BIT  = 22;

  localparam int          WAIT_W         = 4;

  // Access spaces
  typedef enum logic [1:0] {
    SPACE_PROG = 2'b00,
    SPACE_DATA = 2'b01,
    SPACE_IO   = 2'b10
  } ewsg_space_t;

  typedef struct packed {
    ewsg_space_t space;
    logic [22:0] addr;
  } ewsg_acc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } ewsg_state_t;

endpackage : ewsg_pkg

// File: design/ewsg_top.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Any external access can be lengthened by zero to fourteen machine cycles.
// - Devices needing more waits stretch via ready input; it is always honoured.
// - All range counts zero stops the wait counter clock enable to save power.
// - Low fifteen bits hold five 3-bit counts, one per address range.
// - After reset all range counts are seven.
// - Bit 15, reset zero, selects the program range address split.
// - Bits 14 to 12 give the I/O space base count.
// - Bits 11 to 9 give the upper data half base count.
// - Bits 8 to 6 give the lower data half base count.
// - Bits 5 to 3 apply to upper program accesses per split bit.
// - Bits 2 to 0 apply to lower program accesses per split bit.
// - Multiplier bit 0, reset zero, doubles every base count when set.
// - Multiplier register bits 15 to 1 read zero and ignore writes.
module ewsg_top
  import ewsg_pkg::*;
(
  input  wire logic        REF_CLK,    // Machine clock
  input  wire logic        RESET,      // Asynchronous reset, active high
  input  wire logic        PSEL,       // APB select
  input  wire logic        PENABLE,    // APB access phase
  input  wire logic        PWRITE,     // APB direction
  input  wire logic [11:0] PADDR,      // APB byte address
  input  wire logic [31:0] PWDATA,     // APB write data
  output logic      [31:0] PRDATA,     // APB read data
  output logic             PREADY,     // APB ready
  output logic             PSLVERR,    // APB error on unmapped address
  input  wire logic        ACC_REQ,    // External access request, held until done
  input  wire ewsg_acc_t   ACC,        // Space and address of the access
  input  wire logic        READY_IN,   // External ready pin
  output logic             ACC_BUSY,   // Access in progress
  output logic             ACC_DONE,   // One-cycle pulse: access complete
  output logic             WAIT_CLK_ON // Wait counter enabled
);

  function automatic logic [2:0] field3(input logic [15:0] cfg, input int lsb);
    field3 = cfg[lsb +: 3];
  endfunction : field3

  // Base count for the access: space and address pick the field
  function automatic logic [2:0] base_waits(input logic [15:0] cfg, input ewsg_acc_t a);
    logic upper;
    upper = 1'b0;
    unique case (a.space)
      SPACE_IO: begin
        base_waits = field3(cfg, IO_LSB);
      end
      SPACE_DATA: begin
        if (a.addr[DATA_SPLIT_BIT]) begin
          base_waits = field3(cfg, DHI_LSB);
        end else begin
          base_waits = field3(cfg, DLO_LSB);
        end
      end
      default: begin
        upper = cfg[SPLIT_BIT] ? a.addr[PROG_WIDE_BIT] : a.addr[DATA_SPLIT_BIT];
        base_waits = upper ? field3(cfg, PHI_LSB) : field3(cfg, PLO_LSB);
      end
    endcase
  endfunction : base_waits

  // Register file
  logic [15:0] wait_count_config;
  logic        wait_double_select;
  logic [15:0] next_wait_count_config;
  logic        next_wait_double_select;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        hit_cfg;
  logic        hit_mul;
  logic        wr_done;

  always_comb begin
    hit_cfg = PADDR[11:0] == {2'b00, CFG_BYTE_ADDR};
    hit_mul = PADDR[11:0] == {2'b00, MUL_BYTE_ADDR};
    wr_done = PSEL && PENABLE && PREADY && PWRITE;
    next_wait_count_config  = wait_count_config;
    next_wait_double_select = wait_double_select;
    next_prdata  = PRDATA;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      next_pready  = 1'b1;
      next_pslverr = !(hit_cfg || hit_mul);
      next_prdata  = 32'h0000_0000;
      if (!PWRITE && hit_cfg) begin
        next_prdata = {16'h0000, wait_count_config};
      end else if (!PWRITE && hit_mul) begin
        next_prdata = {31'h0000_0000, wait_double_select};
      end
    end
    if (wr_done && hit_cfg) begin
      next_wait_count_config = PWDATA[15:0];
    end
    if (wr_done && hit_mul) begin
      next_wait_double_select = PWDATA[DOUBLE_BIT];
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      wait_count_config  <= CFG_RESET;
      wait_double_select <= DOUBLE_RESET;
      PRDATA             <= 32'h0000_0000;
      PREADY             <= 1'b0;
      PSLVERR            <= 1'b0;
    end else begin
      wait_count_config  <= next_wait_count_config;
      wait_double_select <= next_wait_double_select;
      PRDATA             <= next_prdata;
      PREADY             <= next_pready;
      PSLVERR            <= next_pslverr;
    end
  end

  // Ready pin synchroniser
  logic ready_meta;
  logic ready_sync;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
    end else begin
      ready_meta <= READY_IN;
      ready_sync <= ready_meta;
    end
  end

  // Access sequencer
  ewsg_state_t       state;
  ewsg_state_t       next_state;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait_cnt;
  logic [WAIT_W-1:0] scaled;
  logic              gate_on;
  logic              next_gate_on;
  logic              next_busy;
  logic              next_done;

  always_comb begin
    scaled = wait_double_select ? {base_waits(wait_count_config, ACC), 1'b0}
                                : {1'b0, base_waits(wait_count_config, ACC)};
    next_gate_on = |wait_count_config[14:0];
    next_state    = state;
    next_wait_cnt = wait_cnt;
    next_done     = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (ACC_REQ) begin
          next_wait_cnt = scaled;
          next_state    = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_cnt != '0) begin
          if (gate_on) begin
            next_wait_cnt = wait_cnt - 1'b1;
          end
        end else if (ready_sync) begin
          next_done  = 1'b1;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = next_state == ST_WAIT;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state       <= ST_IDLE;
      wait_cnt    <= '0;
      gate_on     <= 1'b1;
      ACC_BUSY    <= 1'b0;
      ACC_DONE    <= 1'b0;
      WAIT_CLK_ON <= 1'b1;
    end else begin
      state       <= next_state;
      wait_cnt    <= next_wait_cnt;
      gate_on     <= next_gate_on;
      ACC_BUSY    <= next_busy;
      ACC_DONE    <= next_done;
      WAIT_CLK_ON <= next_gate_on;
    end
  end

endmodule : ewsg_top
`default_nettype wire

// File: verification/ewsg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ewsg_properties
  import ewsg_pkg::*;
(
  input wire logic        REF_CLK,    // Clock
  input wire logic        RESET,      // Reset
  input wire logic        PSEL,       // Select
  input wire logic        PENABLE,    // Access
  input wire logic        PWRITE,     // Write
  input wire logic [11:0] PADDR,      // Address
  input wire logic [31:0] PWDATA,     // Wdata
  input wire logic [31:0] PRDATA,     // Rdata
  input wire logic        PREADY,     // Ready
  input wire logic        PSLVERR,    // Error
  input wire logic        READY_IN,   // Pin
  input wire logic        ACC_BUSY,   // Busy
  input wire logic        ACC_DONE,   // Done
  input wire logic        WAIT_CLK_ON // Gate
);
  localparam logic [11:0] CA = 12'(CFG_BYTE_ADDR);
  localparam logic [11:0] MA = 12'(MUL_BYTE_ADDR);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_cfg_wr; PSEL && PENABLE && PREADY && PWRITE && PADDR == CA; endsequence
  chk_apb_ready: assert property (s_setup |=> PREADY)
    else $error("setup not answered");
  chk_unmapped_err: assert property (s_setup ##0 (!PWRITE && PADDR != CA && PADDR != MA) |=> PSLVERR && PRDATA == 0)
    else $error("unmapped read not refused");
  chk_mul_reserved: assert property (s_setup ##0 (!PWRITE && PADDR == MA) |=> PRDATA[31:1] == 0)
    else $error("reserved bits set");
  chk_gate_off: assert property (s_cfg_wr ##0 PWDATA[14:0] == 0 |-> ##[1:2] !WAIT_CLK_ON)
    else $error("gate stays on");
  chk_gate_on: assert property (s_cfg_wr ##0 PWDATA[14:0] != 0 |-> ##[1:2] WAIT_CLK_ON)
    else $error("gate stays off");
  chk_done_ready: assert property (ACC_DONE |-> $past(READY_IN, 3))
    else $error("done without ready");
  chk_done_idle: assert property (ACC_DONE |-> !ACC_BUSY && $past(ACC_BUSY))
    else $error("done out of wait");
  chk_busy_bound: assert property ($rose(ACC_BUSY) |-> ##[1:40] ACC_DONE)
    else $error("access never ends");
endmodule : ewsg_properties
`default_nettype wire

// File: verification/ewsg_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ewsg_ext_dev (
  input  wire logic       clk,   // Clock
  input  wire logic       req,   // Access on
  input  wire logic [3:0] stall, // Slow cycles
  output logic            ready  // Ready pin
);
  logic [4:0] cnt = 5'h00;
  logic       tog = 1'b0;
  always_ff @(posedge clk) begin
    cnt <= req ? cnt + 5'h01 : 5'h00;
    tog <= ~tog;
  end
  // Released pin toggles, never a stale level
  assign ready = req ? (cnt >= {1'b0, stall}) : tog;
endmodule : ewsg_ext_dev
`default_nettype wire

// File: verification/test_ewsg_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("Error %0t bad %0h", $time, a); end end
module test_ewsg_top;
  import ewsg_pkg::*;
  localparam logic [11:0] CA = 12'(CFG_BYTE_ADDR);
  localparam logic [11:0] MA = 12'(MUL_BYTE_ADDR);
  logic REF_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ACC_REQ = 1'b0;
  logic PREADY, PSLVERR, READY_IN, ACC_BUSY, ACC_DONE, WAIT_CLK_ON, err, dbl = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
  logic [15:0] cfg = 16'h7FFF;
  logic [3:0] stall = 4'h0;
  ewsg_acc_t ACC = '0;
  int miscompares = 0, cmp_count = 0, cyc = 0, lat, n;
  ewsg_top ewsg_top_inst (.*);
  ewsg_ext_dev ewsg_ext_dev_inst (.clk(REF_CLK), .req(ACC_REQ), .stall(stall), .ready(READY_IN));
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(negedge REF_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    @(posedge REF_CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb
  function automatic int exp_wait(input ewsg_acc_t x);
    logic [2:0] f;
    if (x.space == SPACE_IO) f = cfg[14:12];
    else if (x.space == SPACE_DATA) f = x.addr[15] ? cfg[11:9] : cfg[8:6];
    else f = (cfg[15] ? x.addr[22] : x.addr[15]) ? cfg[5:3] : cfg[2:0];
    return dbl ? 2 * f : f;
  endfunction : exp_wait
  task automatic acc(input ewsg_acc_t x, input logic [3:0] st);
    ACC <= x;
    stall <= st;
    ACC_REQ <= 1'b1;
    n = exp_wait(x);
    lat = 0;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    `CHK(ACC_BUSY, 1'b1)
    do begin
      @(negedge REF_CLK);
      lat++;
    end while (ACC_DONE !== 1'b1 && lat < 60);
    @(posedge REF_CLK);
    ACC_REQ <= 1'b0;
    if (st == 4'h0 && n >= 1) `CHK(lat, n + 1)
    else `CHK(lat >= n + 1 && lat <= n + st + 2, 1'b1)
    @(posedge REF_CLK);
  endtask : acc
  initial begin
    void'($urandom(18));
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    apb(1'b0, CA, 32'h0000_0000);
    `CHK(rd, 32'h0000_7FFF)
    apb(1'b0, MA, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    acc('{SPACE_PROG, 23'h00_1234}, 4'h0);
    apb(1'b1, MA, 32'hFFFF_FFFF);
    dbl = 1'b1;
    apb(1'b0, MA, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    acc('{SPACE_IO, 23'h00_FFFF}, 4'h0);
    apb(1'b0, 12'h0A4, 32'hFFFF_FFFF);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, CA, 32'h0000_0000);
    cfg = 16'h0000;
    @(posedge REF_CLK);
    `CHK(WAIT_CLK_ON, 1'b0)
    acc('{SPACE_DATA, 23'h00_8000}, 4'h2);
    for (int i = 0; i < 60; i++) begin
      if (i % 6 == 0) begin
        cfg = 16'($urandom);
        dbl = 1'($urandom);
        apb(1'b1, CA, {16'h0000, cfg});
        apb(1'b1, MA, {31'h0000_0000, dbl});
      end
      acc('{ewsg_space_t'(2'($urandom_range(2))), 23'($urandom)}, (i % 2) ? 4'($urandom_range(7)) : 4'h0);
    end
    report_and_stop();
  end
endmodule : test_ewsg_top
bind ewsg_top ewsg_properties ewsg_properties_inst (.*);
`default_nettype wire
